// ===== core/slpc_pkg.sv
package slpc_pkg;

  // ***********************************************************
  // Reset values of the register fields
  // ***********************************************************
  localparam logic [5:0] MAIN_DIV_RST = 6'h1b;
  localparam logic [1:0] OUT_DIV_RST = 2'h0;
  localparam logic [5:0] DP_CODE_RST = 6'h3a;
  localparam logic [4:0] CI_RST = 5'h03;
  localparam logic [9:0] CP_RST = 10'h00c;
  localparam logic [10:0] FT_RST = 11'h200;
  localparam logic [1:0] SHIFT_RST = 2'h2;
  localparam logic WINDOW_RST = 1'b1;
  localparam logic FAST_LOCK_RST = 1'b1;
  localparam logic [2:0] SAR_LIMIT_RST = 3'h0;
  localparam logic [3:0] CAL_TIMER_RST = 4'hf;
  localparam logic [4:0] CAL_MIN_RST = 5'h04;
  localparam logic [4:0] CAL_MAX_RST = 5'h12;
  localparam logic [4:0] CAL_START_RST = 5'h0c;

  // ***********************************************************
  // Field positions and codes
  // ***********************************************************
  localparam int N2_LSB = 0;
  localparam int N1_BIT = 2;
  localparam int N3_LSB = 3;
  localparam int CAL_EN_BIT = 0;
  localparam int CAL_SCHEME_LSB = 1;
  localparam logic [1:0] ALT_PATH_DIV1 = 2'h2;
  localparam logic [1:0] ALT_PATH_DIV2 = 2'h3;
  localparam logic [1:0] NORMAL_PATH = 2'h1;
  localparam logic [1:0] SCHEME_MEASURE = 2'h0;
  localparam logic [1:0] SCHEME_SINGLE = 2'h1;
  localparam logic [1:0] SCHEME_INTERNAL = 2'h2;
  localparam logic [1:0] SCHEME_CONT = 2'h3;

  // ***********************************************************
  // Timing counts in clk_i cycles
  // ***********************************************************
  localparam int LOCK_WIN_LONG = 256;
  localparam int LOCK_WIN_SHORT = 32;
  localparam int SETTLE_CYC = 16;
  localparam int RX_DELAY_CYC = 8;
  localparam int CAL_TICK_CYC = 16;

  // Data-path divider ratio in quarter steps, indexed by code
  localparam logic [6:0] M1_QTR [64] = '{
    7'h04, 7'h08, 7'h0c, 7'h0e, 7'h0e, 7'h0f, 7'h10, 7'h10,
    7'h12, 7'h15, 7'h15, 7'h16, 7'h16, 7'h17, 7'h18, 7'h18,
    7'h18, 7'h1c, 7'h18, 7'h1c, 7'h1c, 7'h1e, 7'h20, 7'h20,
    7'h24, 7'h2a, 7'h28, 7'h2c, 7'h2c, 7'h2e, 7'h30, 7'h30,
    7'h24, 7'h2a, 7'h24, 7'h2a, 7'h2a, 7'h2d, 7'h30, 7'h30,
    7'h36, 7'h3f, 7'h3c, 7'h42, 7'h42, 7'h45, 7'h48, 7'h48,
    7'h30, 7'h38, 7'h30, 7'h38, 7'h38, 7'h3f, 7'h42, 7'h42,
    7'h48, 7'h54, 7'h50, 7'h58, 7'h58, 7'h5c, 7'h60, 7'h60
  };

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_SEARCH = 2'b01,
    LK_TRACK = 2'b11,
    LK_LOCKED = 2'b10
  } slpc_lock_t;

endpackage

// ===== core/slpc_top.sv
module slpc_top #(
  parameter int LOCK_LONG = slpc_pkg::LOCK_WIN_LONG,
  parameter int LOCK_SHORT = slpc_pkg::LOCK_WIN_SHORT,
  parameter int SETTLE = slpc_pkg::SETTLE_CYC,
  parameter int RX_DELAY = slpc_pkg::RX_DELAY_CYC,
  parameter int CAL_TICK = slpc_pkg::CAL_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Pins and analog feedback, asynchronous
  input wire logic pll_rst_i,
  input wire logic phase_ok_i,
  input wire logic osc_fast_i,
  input wire logic jitter_worse_i,
  // Register file fields
  input wire logic [5:0] main_divider_select_i,
  input wire logic [1:0] output_divider_select_i,
  input wire logic [5:0] datapath_divider_code_i,
  input wire logic [1:0] tx_width_sel_i,
  input wire logic [4:0] loop_integral_gain_i,
  input wire logic [9:0] loop_proportional_gain_i,
  input wire logic open_loop_enable_i,
  input wire logic [10:0] fine_tune_value_i,
  input wire logic [2:0] coarse_cap_switch_i,
  input wire logic coarse_cap_autotune_i,
  input wire logic lock_overwrite_i,
  input wire logic lock_window_length_i,
  input wire logic [1:0] unlocked_gain_shift_i,
  input wire logic binary_search_lock_enable_i,
  input wire logic [2:0] binary_search_limit_i,
  input wire logic open_loop_force_locked_i,
  input wire logic force_unlocked_i,
  input wire logic reference_clock_bypass_i,
  input wire logic reference_input_type_i,
  input wire logic settings_source_select_i,
  input wire logic pll_power_enable_i,
  input wire logic [2:0] self_cal_mode_i,
  input wire logic [3:0] self_cal_timer_limit_i,
  input wire logic [4:0] self_cal_gain_min_i,
  input wire logic [4:0] self_cal_gain_max_i,
  input wire logic [4:0] self_cal_gain_start_i,
  // Clock generation results
  output logic [5:0] bit_rate_mult_o,
  output logic [2:0] bit_rate_div_o,
  output logic [1:0] alternative_path_code_o,
  output logic datapath_clock_o,
  output logic ref_diff_sel_o,
  output logic ref_bypass_o,
  output logic cfg_error_o,
  // Loop state
  output logic [10:0] osc_tune_o,
  output logic [2:0] coarse_cap_o,
  output logic [7:0] eff_integral_gain_o,
  output logic [12:0] eff_proportional_gain_o,
  output logic locked_o,
  output logic [1:0] self_cal_scheme_o,
  output logic self_cal_done_o,
  // Data-path resets
  output logic tx_rst_o,
  output logic rx_rst_o
);

  initial begin
    if (LOCK_SHORT < 1 || LOCK_LONG <= LOCK_SHORT || LOCK_LONG > 65535 ||
        SETTLE < 1 || SETTLE > 255 || RX_DELAY < 1 || RX_DELAY > 255 ||
        CAL_TICK < 1 || CAL_TICK > 255)
      $error("slpc_top: timing parameter out of range");
  end

  // ***********************************************************
  // Input synchronisers
  // ***********************************************************
  logic [3:0] async_in, s1_q, s2_q, s3_q, flt_q;
  assign async_in = {jitter_worse_i, osc_fast_i, phase_ok_i, pll_rst_i};

  // A pin counts only once stages two and three agree
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        s1_q[g] <= 1'b0;
        s2_q[g] <= 1'b0;
        s3_q[g] <= 1'b0;
        flt_q[g] <= 1'b0;
      end else begin
        s1_q[g] <= async_in[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) flt_q[g] <= s3_q[g];
      end
    end
  end

  logic pll_rst, phase_ok, osc_fast, jit_worse, run;
  assign pll_rst = flt_q[0];
  assign phase_ok = flt_q[1];
  assign osc_fast = flt_q[2];
  assign jit_worse = flt_q[3];
  assign run = pll_power_enable_i && !pll_rst;

  // ***********************************************************
  // Settings source
  // ***********************************************************
  logic use_reg;
  logic [5:0] main_sel, dp_code;
  logic [1:0] out_sel, shift_sel;
  logic [4:0] ci_sel;
  logic [9:0] cp_sel;
  logic [10:0] ft_sel;
  logic win_sel, fast_sel;
  assign use_reg = settings_source_select_i;
  assign main_sel = use_reg ? main_divider_select_i
                            : slpc_pkg::MAIN_DIV_RST;
  assign out_sel = use_reg ? output_divider_select_i
                           : slpc_pkg::OUT_DIV_RST;
  assign dp_code = use_reg ? datapath_divider_code_i
                           : slpc_pkg::DP_CODE_RST;
  assign ci_sel = use_reg ? loop_integral_gain_i : slpc_pkg::CI_RST;
  assign cp_sel = use_reg ? loop_proportional_gain_i : slpc_pkg::CP_RST;
  assign ft_sel = use_reg ? fine_tune_value_i : slpc_pkg::FT_RST;
  assign shift_sel = use_reg ? unlocked_gain_shift_i
                             : slpc_pkg::SHIFT_RST;
  assign win_sel = use_reg ? lock_window_length_i : slpc_pkg::WINDOW_RST;
  assign fast_sel = use_reg ? binary_search_lock_enable_i
                            : slpc_pkg::FAST_LOCK_RST;

  // ***********************************************************
  // Divider decode, frozen while the PLL runs
  // ***********************************************************
  logic [2:0] n1, n2, n3, m3;
  logic bad_cfg;
  always_comb begin
    n1 = main_sel[slpc_pkg::N1_BIT] ? 3'h2 : 3'h1;
    unique case (main_sel[slpc_pkg::N2_LSB +: 2])
      2'b00: n2 = 3'h3;
      2'b01: n2 = 3'h2;
      2'b10: n2 = 3'h4;
      2'b11: n2 = 3'h5;
    endcase
    // Forbidden codes fall back to the reset decode and flag it
    unique case (main_sel[slpc_pkg::N3_LSB +: 2])
      2'b00: n3 = 3'h3;
      2'b10: n3 = 3'h4;
      default: n3 = 3'h5;
    endcase
    unique case (out_sel)
      2'b01: m3 = 3'h2;
      2'b11: m3 = 3'h4;
      default: m3 = 3'h1;
    endcase
    bad_cfg = (main_sel[slpc_pkg::N3_LSB +: 2] == 2'b01) ||
              (out_sel == 2'b10);
  end

  logic [6:0] m1q_q;
  logic m4_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_rate_mult_o <= 6'h19;
      bit_rate_div_o <= 3'h1;
      alternative_path_code_o <= slpc_pkg::NORMAL_PATH;
      m1q_q <= 7'h50;
      m4_q <= 1'b0;
      cfg_error_o <= 1'b0;
    end else if (!run) begin
      bit_rate_mult_o <= 6'(n1) * 6'(n2) * 6'(n3);
      bit_rate_div_o <= m3;
      m1q_q <= slpc_pkg::M1_QTR[dp_code];
      m4_q <= tx_width_sel_i[1];
      cfg_error_o <= bad_cfg;
      if (dp_code == 6'h00)
        alternative_path_code_o <= slpc_pkg::ALT_PATH_DIV1;
      else if (dp_code == 6'h01)
        alternative_path_code_o <= slpc_pkg::ALT_PATH_DIV2;
      else
        alternative_path_code_o <= slpc_pkg::NORMAL_PATH;
    end
  end

  // Fractional divider: steps of four against M1 (quarters) times M4
  logic [7:0] den, acc_q;
  logic [8:0] acc_nx;
  assign den = m4_q ? {m1q_q, 1'b0} : {1'b0, m1q_q};
  assign acc_nx = {1'b0, acc_q} + 9'h004;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_q <= 8'h00;
      datapath_clock_o <= 1'b0;
    end else if (!run || tx_rst_o) begin
      acc_q <= 8'h00;
      datapath_clock_o <= 1'b0;
    end else if (acc_nx >= {1'b0, den}) begin
      acc_q <= 8'(acc_nx - {1'b0, den});
      datapath_clock_o <= 1'b1;
    end else begin
      acc_q <= acc_nx[7:0];
      datapath_clock_o <= 1'b0;
    end
  end

  // ***********************************************************
  // Reference selection
  // ***********************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_diff_sel_o <= 1'b0;
      ref_bypass_o <= 1'b0;
    end else begin
      ref_diff_sel_o <= reference_input_type_i;
      ref_bypass_o <= reference_clock_bypass_i;
    end
  end

  // ***********************************************************
  // Lock acquisition
  // ***********************************************************
  slpc_pkg::slpc_lock_t st_q;
  logic [3:0] bit_q;
  logic [7:0] settle_q;
  logic [15:0] win_q;
  logic [10:0] ft_q;
  logic settled, step_bit;
  assign settled = (settle_q == 8'(SETTLE - 1));
  // Full index compare: bit 8 must not look like limit 0
  assign step_bit = (bit_q == {1'b0, binary_search_limit_i}) ||
                    (bit_q == 4'h0);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= slpc_pkg::LK_IDLE;
      bit_q <= 4'ha;
      settle_q <= 8'h00;
      win_q <= 16'h0000;
      ft_q <= slpc_pkg::FT_RST;
      coarse_cap_o <= 3'h0;
    end else if (!run) begin
      st_q <= slpc_pkg::LK_IDLE;
      settle_q <= 8'h00;
      win_q <= 16'h0000;
    end else begin
      settle_q <= settled ? 8'h00 : settle_q + 8'h01;
      unique case (st_q)
        slpc_pkg::LK_IDLE: begin
          bit_q <= 4'ha;
          settle_q <= 8'h00;
          if (!coarse_cap_autotune_i)
            coarse_cap_o <= coarse_cap_switch_i;
          if (fast_sel && !open_loop_enable_i) begin
            ft_q <= 11'h400;
            st_q <= slpc_pkg::LK_SEARCH;
          end else begin
            ft_q <= ft_sel;
            st_q <= slpc_pkg::LK_TRACK;
          end
        end
        slpc_pkg::LK_SEARCH: if (settled) begin
          // Try each bit from bit 10 down to the limit bit; keep it unless too fast
          logic [10:0] nx;
          nx = ft_q;
          if (osc_fast) nx[bit_q] = 1'b0;
          if (!step_bit) begin
            nx[bit_q - 4'h1] = 1'b1;
            bit_q <= bit_q - 4'h1;
            ft_q <= nx;
          end else if (coarse_cap_autotune_i && &nx &&
                       coarse_cap_o != 3'h7) begin
            coarse_cap_o <= coarse_cap_o + 3'h1;
            st_q <= slpc_pkg::LK_IDLE;
          end else if (coarse_cap_autotune_i && nx == 11'h000 &&
                       coarse_cap_o != 3'h0) begin
            coarse_cap_o <= coarse_cap_o - 3'h1;
            st_q <= slpc_pkg::LK_IDLE;
          end else begin
            ft_q <= nx;
            st_q <= slpc_pkg::LK_TRACK;
          end
        end
        slpc_pkg::LK_TRACK: begin
          if (!phase_ok) win_q <= 16'h0000;
          else if (win_q == (win_sel ? 16'(LOCK_SHORT - 1)
                                     : 16'(LOCK_LONG - 1))) begin
            win_q <= 16'h0000;
            st_q <= slpc_pkg::LK_LOCKED;
          end else win_q <= win_q + 16'h0001;
          if (settled && !phase_ok && !open_loop_enable_i)
            ft_q <= osc_fast ? ft_q - 11'h001 : ft_q + 11'h001;
        end
        slpc_pkg::LK_LOCKED: if (!phase_ok) st_q <= slpc_pkg::LK_TRACK;
      endcase
    end
  end

  logic raw_lock, lock_nx;
  assign raw_lock = (st_q == slpc_pkg::LK_LOCKED) && run;
  always_comb begin
    if (force_unlocked_i) lock_nx = 1'b0;
    else if (lock_overwrite_i) lock_nx = 1'b1;
    else if (open_loop_enable_i && open_loop_force_locked_i)
      lock_nx = 1'b1;
    else lock_nx = raw_lock;
  end

  // ***********************************************************
  // Self-calibration of the proportional gain
  // ***********************************************************
  logic cal_on, cal_tick;
  logic [11:0] cal_tmr_q;
  logic [4:0] cal_cp_q;
  logic cal_up_q;
  logic [1:0] flips_q;
  assign cal_on = self_cal_mode_i[slpc_pkg::CAL_EN_BIT] && raw_lock;
  assign cal_tick = (cal_tmr_q ==
      12'(({8'h00, self_cal_timer_limit_i} + 12'h001) * 12'(CAL_TICK) - 1));

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_tmr_q <= 12'h000;
      cal_cp_q <= slpc_pkg::CAL_START_RST;
      cal_up_q <= 1'b1;
      flips_q <= 2'h0;
      self_cal_done_o <= 1'b0;
    end else if (!cal_on) begin
      cal_tmr_q <= 12'h000;
      cal_cp_q <= self_cal_gain_start_i;
      cal_up_q <= 1'b1;
      flips_q <= 2'h0;
      self_cal_done_o <= 1'b0;
    end else if (!self_cal_done_o) begin
      cal_tmr_q <= cal_tick ? 12'h000 : cal_tmr_q + 12'h001;
      if (cal_tick) begin
        // Reverse on worse jitter; two reversals bracket the optimum
        logic up;
        up = jit_worse ? !cal_up_q : cal_up_q;
        cal_up_q <= up;
        if (jit_worse && flips_q != 2'h3) flips_q <= flips_q + 2'h1;
        if (up && cal_cp_q < self_cal_gain_max_i)
          cal_cp_q <= cal_cp_q + 5'h01;
        else if (!up && cal_cp_q > self_cal_gain_min_i)
          cal_cp_q <= cal_cp_q - 5'h01;
        if (jit_worse && flips_q != 2'h0 &&
            self_cal_mode_i[2:1] != slpc_pkg::SCHEME_CONT &&
            self_cal_mode_i[2:1] != slpc_pkg::SCHEME_INTERNAL)
          self_cal_done_o <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // Loop outputs
  // ***********************************************************
  logic cal_apply;
  logic [9:0] cp_use;
  assign cal_apply = cal_on &&
                     self_cal_mode_i[2:1] != slpc_pkg::SCHEME_MEASURE;
  assign cp_use = cal_apply ? {5'h00, cal_cp_q} : cp_sel;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_tune_o <= slpc_pkg::FT_RST;
      eff_integral_gain_o <= 8'h00;
      eff_proportional_gain_o <= 13'h0000;
      locked_o <= 1'b0;
      self_cal_scheme_o <= 2'h0;
    end else begin
      osc_tune_o <= open_loop_enable_i ? ft_sel : ft_q;
      if (raw_lock) begin
        eff_integral_gain_o <= {3'h0, ci_sel};
        eff_proportional_gain_o <= {3'h0, cp_use};
      end else begin
        eff_integral_gain_o <= 8'({3'h0, ci_sel} << shift_sel);
        eff_proportional_gain_o <= 13'({3'h0, cp_use} << shift_sel);
      end
      locked_o <= lock_nx;
      self_cal_scheme_o <= self_cal_mode_i[2:1];
    end
  end

  // ***********************************************************
  // Chained data-path reset release
  // ***********************************************************
  // Cycles since tx release, only watched by the delay check
  logic [7:0] tx_low_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_low_q <= 8'h00;
    end else if (tx_rst_o) begin
      tx_low_q <= 8'h00;
    end else if (tx_low_q != 8'hff) begin
      tx_low_q <= tx_low_q + 8'h01;
    end
  end

  logic [7:0] rx_cnt_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_rst_o <= 1'b1;
      rx_rst_o <= 1'b1;
      rx_cnt_q <= 8'h00;
    end else if (!run || !lock_nx) begin
      tx_rst_o <= 1'b1;
      rx_rst_o <= 1'b1;
      rx_cnt_q <= 8'h00;
    end else begin
      tx_rst_o <= 1'b0;
      if (!tx_rst_o && rx_cnt_q != 8'(RX_DELAY - 1))
        rx_cnt_q <= rx_cnt_q + 8'h01;
      if (!tx_rst_o && rx_cnt_q == 8'(RX_DELAY - 1)) rx_rst_o <= 1'b0;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  sequence tx_free_s;
    $fell(tx_rst_o);
  endsequence
  sequence rx_free_s;
    $fell(rx_rst_o);
  endsequence

  force_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    force_unlocked_i |=> !locked_o) else $error("lock not forced low");
  overwrite_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !force_unlocked_i && lock_overwrite_i |=> locked_o)
    else $error("lock overwrite ignored");
  open_tune_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    open_loop_enable_i |=> osc_tune_o == $past(ft_sel))
    else $error("open loop tune wrong");
  rst_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !locked_o |-> tx_rst_o && rx_rst_o) else $error("reset released early");
  rx_order_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_free_s |-> rx_rst_o)
    else $error("rx release order wrong");
  rx_delay_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_free_s |-> !tx_rst_o && tx_low_q == 8'(RX_DELAY))
    else $error("rx release delay wrong");
  div_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    run && $past(run) |-> $stable(m1q_q) && $stable(bit_rate_div_o))
    else $error("divider changed while running");
  alt_path_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !run && dp_code == 6'h01 |=> alternative_path_code_o == 2'h3)
    else $error("alternative path code wrong");
  gain_shift_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !raw_lock && shift_sel == 2'h2 && !cal_apply |=>
    eff_proportional_gain_o == 13'($past(cp_sel)) * 13'h0004)
    else $error("unlocked gain shift wrong");
  cal_bound_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cal_on && $past(cal_on) && $past(cal_cp_q) <= self_cal_gain_max_i &&
    $stable(self_cal_gain_max_i) |-> cal_cp_q <= self_cal_gain_max_i)
    else $error("calibrated gain above maximum");
  dp_default_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !run && dp_code == 6'h3a |=> m1q_q == 7'h50)
    else $error("default ratio not twenty");

endmodule

// ===== bench/slpc_analog_model.sv
module slpc_analog_model #(
  parameter logic [10:0] TARGET = 11'h2a0
) (
  // Fabric side
  input wire logic clk_i,
  input wire logic [10:0] osc_tune_i,
  input wire logic datapath_clock_i,
  output int core_edges_o,
  // Analog feedback
  output logic phase_ok_o,
  output logic osc_fast_o,
  output logic jitter_worse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // Oscillator: band of +/-4 so tracking can settle
  // ************************************************
  assign osc_fast_o = osc_tune_i > TARGET;
  assign phase_ok_o = osc_tune_i >= TARGET - 11'h004 &&
    osc_tune_i <= TARGET + 11'h004;
  assign jitter_worse_o = 1'b0;
  initial core_edges_o = 0;
  // Data-path clock pulses are counted into core_edges_o
  always @(posedge clk_i) begin
    if (datapath_clock_i) core_edges_o <= core_edges_o + 1;
  end
endmodule

// ===== bench/serial_link_pll_config_bench.sv
module serial_link_pll_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // Inputs start at their register reset values
  // ************************************************
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pll_rst_i = 1'b0;
  logic phase_ok_i, osc_fast_i, jitter_worse_i;
  logic [5:0] main_divider_select_i = 6'h1b;
  logic [1:0] output_divider_select_i = 2'h0;
  logic [5:0] datapath_divider_code_i = 6'h3a;
  logic [1:0] tx_width_sel_i = 2'h0;
  logic [4:0] loop_integral_gain_i = 5'h03;
  logic [9:0] loop_proportional_gain_i = 10'h00c;
  logic open_loop_enable_i = 1'b0;
  logic [10:0] fine_tune_value_i = 11'h200;
  logic [2:0] coarse_cap_switch_i = 3'h0;
  logic coarse_cap_autotune_i = 1'b1;
  logic lock_overwrite_i = 1'b0;
  logic lock_window_length_i = 1'b1;
  logic [1:0] unlocked_gain_shift_i = 2'h2;
  logic binary_search_lock_enable_i = 1'b1;
  logic [2:0] binary_search_limit_i = 3'h0;
  logic open_loop_force_locked_i = 1'b1;
  logic force_unlocked_i = 1'b0;
  logic reference_clock_bypass_i = 1'b0;
  logic reference_input_type_i = 1'b0;
  logic settings_source_select_i = 1'b1;
  logic pll_power_enable_i = 1'b0;
  logic [2:0] self_cal_mode_i = 3'h0;
  logic [3:0] self_cal_timer_limit_i = 4'hf;
  logic [4:0] self_cal_gain_min_i = 5'h04;
  logic [4:0] self_cal_gain_max_i = 5'h12;
  logic [4:0] self_cal_gain_start_i = 5'h0c;
  logic [5:0] bit_rate_mult_o;
  logic [2:0] bit_rate_div_o, coarse_cap_o;
  logic [1:0] alternative_path_code_o, self_cal_scheme_o;
  logic datapath_clock_o, ref_diff_sel_o, ref_bypass_o, cfg_error_o;
  logic [10:0] osc_tune_o;
  logic [7:0] eff_integral_gain_o;
  logic [12:0] eff_proportional_gain_o;
  logic locked_o, self_cal_done_o, tx_rst_o, rx_rst_o;
  int core_edges, e0, n_fail = 0, total_checks = 0, cyc_cnt = 0;
  slpc_top #(.LOCK_LONG(8), .LOCK_SHORT(4), .SETTLE(8), .RX_DELAY(2),
    .CAL_TICK(1)) dut (.*);
  slpc_analog_model model (.clk_i(clk_i), .osc_tune_i(osc_tune_o),
    .datapath_clock_i(datapath_clock_o), .core_edges_o(core_edges),
    .phase_ok_o(phase_ok_i), .osc_fast_o(osc_fast_i),
    .jitter_worse_o(jitter_worse_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Hang guard, well above the slowest lock search
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic dec(input logic [5:0] m, input logic [1:0] o,
      input logic [5:0] c, input logic [5:0] em, input logic [2:0] ed,
      input logic [1:0] ep, input logic ee);
    main_divider_select_i = m;
    output_divider_select_i = o;
    datapath_divider_code_i = c;
    cyc(2);
    chk(bit_rate_mult_o, em);
    chk(bit_rate_div_o, ed);
    chk(alternative_path_code_o, ep);
    chk(cfg_error_o, ee);
  endtask
  task automatic t_decode();
    dec(6'h1b, 2'h0, 6'h3a, 6'h19, 3'h1, 2'h1, 1'b0);
    dec(6'h00, 2'h0, 6'h00, 6'h09, 3'h1, 2'h2, 1'b0);
    dec(6'h01, 2'h1, 6'h01, 6'h06, 3'h2, 2'h3, 1'b0);
    dec(6'h06, 2'h3, 6'h02, 6'h18, 3'h4, 2'h1, 1'b0);
    dec(6'h13, 2'h0, 6'h3f, 6'h14, 3'h1, 2'h1, 1'b0);
    dec(6'h1f, 2'h0, 6'h3a, 6'h32, 3'h1, 2'h1, 1'b0);
    dec(6'h0b, 2'h2, 6'h3a, 6'h19, 3'h1, 2'h1, 1'b1);
    settings_source_select_i = 1'b0;
    dec(6'h00, 2'h1, 6'h3a, 6'h19, 3'h1, 2'h1, 1'b0);
    settings_source_select_i = 1'b1;
    dec(6'h1b, 2'h0, 6'h3a, 6'h19, 3'h1, 2'h1, 1'b0);
    chk(tx_rst_o & rx_rst_o & !locked_o, 1);
  endtask
  task automatic t_open();
    open_loop_enable_i = 1'b1;
    fine_tune_value_i = 11'h155;
    coarse_cap_autotune_i = 1'b0;
    coarse_cap_switch_i = 3'h5;
    tx_width_sel_i = 2'h2;
    // Dividers are only taken while disabled
    cyc(2);
    pll_power_enable_i = 1'b1;
    for (int i = 0; i < 50 && tx_rst_o; i++) cyc(1);
    chk(rx_rst_o, 1);
    cyc(2);
    chk(rx_rst_o, 0);
    chk(osc_tune_o, 11'h155);
    chk(coarse_cap_o, 3'h5);
    chk(locked_o, 1);
    chk(eff_proportional_gain_o, 13'h0030);
    e0 = core_edges;
    cyc(400);
    chk(13'(core_edges - e0), 13'h000a);
    force_unlocked_i = 1'b1;
    cyc(4);
    chk(locked_o | !tx_rst_o, 0);
    chk(eff_proportional_gain_o, 13'h0030);
    chk(eff_integral_gain_o, 8'h0c);
    force_unlocked_i = 1'b0;
    open_loop_force_locked_i = 1'b0;
    lock_overwrite_i = 1'b1;
    cyc(4);
    chk(locked_o, 1);
    datapath_divider_code_i = 6'h00;
    cyc(4);
    chk(alternative_path_code_o, 2'h1);
    pll_power_enable_i = 1'b0;
    cyc(4);
    chk(alternative_path_code_o, 2'h2);
    chk(tx_rst_o, 1);
  endtask
  task automatic t_closed();
    datapath_divider_code_i = 6'h3a;
    tx_width_sel_i = 2'h0;
    open_loop_enable_i = 1'b0;
    lock_overwrite_i = 1'b0;
    coarse_cap_autotune_i = 1'b1;
    lock_window_length_i = 1'b0;
    cyc(2);
    pll_power_enable_i = 1'b1;
    for (int i = 0; i < 4000 && !locked_o; i++) cyc(1);
    chk(locked_o & phase_ok_i, 1);
    chk(locked_o & phase_ok_i, 1);
    chk(eff_integral_gain_o, 8'h03);
    cyc(20);
    e0 = core_edges;
    cyc(400);
    chk(13'(core_edges - e0), 13'h0014);
    for (int m = 0; m < 4; m++) begin
      self_cal_mode_i = {m[1:0], 1'b1};
      cyc(3);
      chk(self_cal_scheme_o, m[1:0]);
    end
    self_cal_mode_i = 3'h5;
    cyc(200);
    chk(eff_proportional_gain_o, 13'h0012);
    chk(self_cal_done_o, 1'b0);
    pll_rst_i = 1'b1;
    cyc(8);
    chk(tx_rst_o & rx_rst_o & !locked_o, 1);
  endtask
  task automatic t_ref();
    reference_input_type_i = 1'b1;
    reference_clock_bypass_i = 1'b1;
    cyc(2);
    chk({ref_diff_sel_o, ref_bypass_o}, 2'h3);
    reference_clock_bypass_i = 1'b0;
    cyc(2);
    chk({ref_diff_sel_o, ref_bypass_o}, 2'h2);
  endtask
  initial begin
    cyc(20);
    sys_rst_i = 1'b0;
    t_decode();
    t_open();
    t_closed();
    t_ref();
    final_report();
  end
endmodule
